//--- supervision_timer_write_sync.v
/*
  Supervision down-counter whose counting advances on a slow tick, with
  all software writes made on the fast clock and carried over.
  Assumes clk is the 200 MHz system clock and the crystal tick arrives
  asynchronously on a pin.
*/
`include "supervision_timer_consts.vh"

// Function
// - Slow tick from 32 kHz crystal or prescaler
// - Slow tick limited to 100 kHz
// - Counter decrements on tick or companion underflow
// - Registers written on the fast clock
// - Writes reach counting logic after slow cycles
// - Active mode transfer within four counter cycles
// - Power save transfer within eight counter cycles
module supervision_timer_write_sync #(
  parameter CNT_W = 16
) (
  // Clock and reset
  clk,
  rst,
  // Slow clock source and power save mode
  xtalClk,
  useXtal,
  powerSave,
  // Register writes on the fast clock
  wrValid,
  wrSel,
  wrData,
  wrReady,
  // Status
  supervCount,
  companionCount,
  serviceMissed,
  timeoutPulse,
  slowTick,
  companionUnderflow
);
  input  wire             clk;
  input  wire             rst;
  input  wire             xtalClk;
  input  wire             useXtal;
  input  wire             powerSave;
  input  wire             wrValid;
  input  wire [1:0]       wrSel;
  input  wire [CNT_W-1:0] wrData;
  output wire             wrReady;
  output reg  [CNT_W-1:0] supervCount;
  output reg  [CNT_W-1:0] companionCount;
  output reg              serviceMissed;
  output reg              timeoutPulse;
  output reg              slowTick;
  output reg              companionUnderflow;

  // ==========================================================================
  // Fast-side configuration
  // ==========================================================================
  reg  [15:0] prescale_q;
  // The floor is worked out as a 32-bit integer; only the low half is a divide
  wire [31:0] minDivFull = `SLOW_MIN_DIV;
  wire [15:0] minDiv     = minDivFull[15:0];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale_q <= `PRESCALE_RESET;
    end else if (wrValid && wrReady && wrSel == `WSEL_CONFIG) begin
      // Divide below the floor would push the tick above 100 kHz
      prescale_q <= ({wrData[15:2], 2'b00} < minDiv) ? minDiv : {wrData[15:2], 2'b00};
    end
  end

  // ==========================================================================
  // Slow tick source
  // ==========================================================================
  reg        xtalS1_q;
  reg        xtalS2_q;
  reg        xtalS3_q;
  reg [15:0] div_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      xtalS1_q <= 1'b0;
      xtalS2_q <= 1'b0;
      xtalS3_q <= 1'b0;
      div_q    <= 16'h0000;
      slowTick <= 1'b0;
    end else begin
      xtalS1_q <= xtalClk;
      xtalS2_q <= xtalS1_q;
      xtalS3_q <= xtalS2_q;
      if (div_q + 16'h0001 >= prescale_q) begin
        div_q <= 16'h0000;
      end else begin
        div_q <= div_q + 16'h0001;
      end
      slowTick <= useXtal ? (xtalS2_q && !xtalS3_q) : (div_q + 16'h0001 >= prescale_q);
    end
  end

  // ==========================================================================
  // Write transfer into the slow domain
  // ==========================================================================
  wire             applyPulse;
  wire [CNT_W+1:0] applyData;

  slow_write_sync #(
    .WIDTH(CNT_W + 2)
  ) u_sync (
    .clk       (clk),
    .rst       (rst),
    .wrValid   (wrValid),
    .wrData    ({wrSel, wrData}),
    .wrReady   (wrReady),
    .slowTick  (slowTick),
    .powerSave (powerSave),
    .applyPulse(applyPulse),
    .applyData (applyData)
  );

  // ==========================================================================
  // Slow-side counting logic
  // ==========================================================================
  reg [1:0]       cfg_q;
  reg [CNT_W-1:0] companionReload_q;
  reg [CNT_W-1:0] supervReload_q;

  wire [1:0]       aSel  = applyData[CNT_W+1:CNT_W];
  wire [CNT_W-1:0] aWord = applyData[CNT_W-1:0];
  wire             compZero = (companionCount == {CNT_W{1'b0}});
  wire             decTick  = cfg_q[`CFG_USE_COMPANION] ? companionUnderflow : slowTick;
  // The low byte of the service word must match the key; any other low byte counts as a miss
  wire             serviceOk = applyPulse && aSel == `WSEL_SERVICE && aWord[7:0] == `MATCH_RESET;
  wire             serviceBad = applyPulse && aSel == `WSEL_SERVICE && aWord[7:0] != `MATCH_RESET;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q              <= 2'b10;
      companionReload_q  <= `COMPANION_RESET;
      supervReload_q     <= `SUPERV_RESET;
      companionCount     <= `COMPANION_RESET;
      companionUnderflow <= 1'b0;
      supervCount        <= `SUPERV_RESET;
      serviceMissed      <= 1'b0;
      timeoutPulse       <= 1'b0;
    end else begin
      companionUnderflow <= 1'b0;
      timeoutPulse       <= 1'b0;
      if (applyPulse && aSel == `WSEL_CONFIG) begin
        cfg_q <= aWord[1:0];
      end
      if (applyPulse && aSel == `WSEL_COMPANION) begin
        companionReload_q <= aWord;
      end
      if (applyPulse && aSel == `WSEL_RELOAD) begin
        supervReload_q <= aWord;
      end
      if (slowTick) begin
        if (compZero) begin
          companionCount     <= companionReload_q;
          companionUnderflow <= 1'b1;
        end else begin
          companionCount <= companionCount - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      if (serviceBad) begin
        serviceMissed <= 1'b1;
      end
      if (serviceOk) begin
        supervCount <= supervReload_q;
      end else if (cfg_q[`CFG_ENABLE] && decTick) begin
        if (supervCount == {CNT_W{1'b0}}) begin
          supervCount   <= supervReload_q;
          timeoutPulse  <= 1'b1;
          serviceMissed <= 1'b1;
        end else begin
          supervCount <= supervCount - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // supervision_timer_write_sync

//--- supervision_timer_consts.vh
/*
  Constants for the supervision timer with fast-to-slow write transfer.
  Assumes a 200 MHz system clock; all slow rates are enable pulses.
*/
`ifndef SUPERVISION_TIMER_CONSTS_VH
`define SUPERVISION_TIMER_CONSTS_VH

// ==========================================================================
// Clock figures
// ==========================================================================
`define CLK_FREQ_KHZ        200000
`define XTAL_FREQ_KHZ       32
`define SLOW_MAX_FREQ_KHZ   100
// Least prescaler divide that keeps the slow tick at or under 100 kHz
`define SLOW_MIN_DIV        ((`CLK_FREQ_KHZ + `SLOW_MAX_FREQ_KHZ - 1) / `SLOW_MAX_FREQ_KHZ)

// ==========================================================================
// Write transfer bounds in counter clock cycles
// ==========================================================================
`define XFER_MAX_ACTIVE     4'h4
`define XFER_MAX_SAVE       4'h8

// ==========================================================================
// Reset values
// ==========================================================================
`define PRESCALE_RESET      16'h07d0
`define COMPANION_RESET     16'h0010
`define SUPERV_RESET        16'hffff
`define MATCH_RESET         8'h5a

// ==========================================================================
// Write select codes
// ==========================================================================
`define WSEL_CONFIG         2'h0
`define WSEL_COMPANION      2'h1
`define WSEL_RELOAD         2'h2
`define WSEL_SERVICE        2'h3

// Config word fields
`define CFG_USE_COMPANION   0
`define CFG_ENABLE          1

`endif

//--- slow_write_sync.v
/*
  Carries one written word from fast logic into slow-tick logic.
  Assumes the slow side is an enable pulse on the same clock; the word is
  held until the slow side has taken it.
*/
`include "supervision_timer_consts.vh"

module slow_write_sync #(
  parameter WIDTH = 18
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Fast side
  input  wire             wrValid,
  input  wire [WIDTH-1:0] wrData,
  output wire             wrReady,
  // Slow side
  input  wire             slowTick,
  input  wire             powerSave,
  output reg              applyPulse,
  output reg  [WIDTH-1:0] applyData
);

  reg             pending_q;
  reg [WIDTH-1:0] hold_q;
  reg [3:0]       stage_q;

  assign wrReady = !pending_q;

  // Stage count models slow-side capture: 4 ticks active, 8 in power save.
  wire [3:0] stageLimit = powerSave ? `XFER_MAX_SAVE : `XFER_MAX_ACTIVE;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_q  <= 1'b0;
      hold_q     <= {WIDTH{1'b0}};
      stage_q    <= 4'h0;
      applyPulse <= 1'b0;
      applyData  <= {WIDTH{1'b0}};
    end else begin
      applyPulse <= 1'b0;
      if (!pending_q) begin
        if (wrValid) begin
          pending_q <= 1'b1;
          hold_q    <= wrData;
          stage_q   <= 4'h0;
        end
      end else if (slowTick) begin
        // Worst case bound; the word stays frozen until taken
        if (stage_q + 4'h1 >= stageLimit) begin
          pending_q  <= 1'b0;
          applyPulse <= 1'b1;
          applyData  <= hold_q;
        end else begin
          stage_q <= stage_q + 4'h1;
        end
      end
    end
  end

endmodule // slow_write_sync

//--- supervision_timer_properties.sv
/* Assertions on the timer write transfer, slow tick and counter outputs.
   Assumes a bind onto the timer top module. */
module supervision_timer_properties #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input logic             clk,
  input logic             rst,
  // Watched ports
  input logic             powerSave,
  input logic             useXtal,
  input logic             wrValid,
  input logic             wrReady,
  input logic [CNT_W-1:0] supervCount,
  input logic             serviceMissed,
  input logic             timeoutPulse,
  input logic             companionUnderflow,
  input logic             slowTick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Ticks counted while a write is in flight
  // ==========================================
  logic [3:0] xferTicks_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) xferTicks_q <= 4'h0;
    else if (wrValid && wrReady) xferTicks_q <= 4'h0;
    else if (slowTick && !wrReady) xferTicks_q <= xferTicks_q + 4'h1;
  end
  take_holds_a: assert property (wrValid && wrReady |=> !wrReady)
    else $error("ready stayed high after a take");
  rise_on_tick_a: assert property ($rose(wrReady) |-> $past(slowTick))
    else $error("write applied without a tick");
  xfer_bound_a: assert property ($rose(wrReady) |-> xferTicks_q == ($past(powerSave) ? 4'h8 : 4'h4))
    else $error("transfer tick count wrong");
  tick_spacing_a: assert property (slowTick |=> !slowTick [*8])
    else $error("slow ticks too close");
  dec_cause_a: assert property (supervCount == $past(supervCount) - 1'b1 |-> $past(slowTick) || $past(companionUnderflow))
    else $error("counter moved without a tick");
  comp_single_a: assert property (companionUnderflow |=> !companionUnderflow)
    else $error("companion underflow pulse too long");
  timeout_single_a: assert property (timeoutPulse |=> !timeoutPulse)
    else $error("timeout pulse too long");
  timeout_flags_a: assert property (timeoutPulse |=> serviceMissed)
    else $error("timeout not flagged");
  idle_ready_a: assert property (!wrValid && wrReady |=> wrReady)
    else $error("ready dropped while idle");
  cover property ($rose(wrReady) && powerSave);
  cover property ($rose(wrReady) && useXtal);
  cover property (timeoutPulse);
endmodule // supervision_timer_properties

bind supervision_timer_write_sync supervision_timer_properties #(.CNT_W(CNT_W)) chk_u (
  .clk(clk), .rst(rst), .powerSave(powerSave), .useXtal(useXtal), .wrValid(wrValid),
  .wrReady(wrReady), .supervCount(supervCount), .serviceMissed(serviceMissed),
  .timeoutPulse(timeoutPulse), .companionUnderflow(companionUnderflow), .slowTick(slowTick));

//--- cpu_write_model.sv
/* Core-side register writer for the timer.
   Assumes the bench calls put between falling edges. */
module cpu_write_model (
  // Clock
  input  logic        clk,
  // Write port
  input  logic        wrReady,
  output logic        wrValid,
  output logic [1:0]  wrSel,
  output logic [15:0] wrData
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Write offer
  // ==========================================
  initial begin
    wrValid = 1'b0;
    wrSel = 2'h0;
    wrData = 16'h0000;
  end
  // Released bus shows inverted data so a stale word never looks valid
  task automatic put(input logic [1:0] sel, input logic [15:0] data);
    @(negedge clk);
    wrValid = 1'b1;
    wrSel = sel;
    wrData = data;
    while (wrReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    wrValid = 1'b0;
    wrSel = ~sel;
    wrData = ~data;
  endtask
endmodule // cpu_write_model

//--- tb_top.sv
/* Self-checking bench for the supervision timer.
   Assumes the core model and checker are compiled first. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, xtalClk = 1'b0;
  logic        useXtal = 1'b0, powerSave = 1'b0;
  logic        wrValid, wrReady, serviceMissed, timeoutPulse, slowTick, companionUnderflow;
  logic [1:0]  wrSel;
  logic [15:0] wrData, supervCount, companionCount;
  int          badCount = 0, nTests = 0;
  always #2.5 clk = ~clk;
  // Crystal runs free at 32 kHz
  always #15625 xtalClk = ~xtalClk;
  supervision_timer_write_sync dut_u (.clk(clk), .rst(rst), .xtalClk(xtalClk),
    .useXtal(useXtal), .powerSave(powerSave), .wrValid(wrValid), .wrSel(wrSel),
    .wrData(wrData), .wrReady(wrReady), .supervCount(supervCount),
    .companionCount(companionCount), .serviceMissed(serviceMissed),
    .timeoutPulse(timeoutPulse), .slowTick(slowTick), .companionUnderflow(companionUnderflow));
  cpu_write_model cpu_u (.clk(clk), .wrReady(wrReady), .wrValid(wrValid),
    .wrSel(wrSel), .wrData(wrData));
  // ==========================================
  // Checking and closing
  // ==========================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic endSim();
    $display("Checks %0d, mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Counts ticks from take to apply
  task automatic xfer(input logic [1:0] sel, input logic [15:0] data, input int expTicks);
    int ticks = 0;
    int guard = 0;
    cpu_u.put(sel, data);
    while (wrReady !== 1'b1 && guard < 40000) begin
      if (slowTick === 1'b1) ticks++;
      guard++;
      @(negedge clk);
    end
    chk(16'(ticks), 16'(expTicks));
    // The applied word reaches the counting logic one cycle after ready returns
    @(negedge clk);
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic testReset();
    chk(supervCount, 16'hffff);
    chk(companionCount, 16'h0010);
    chk({15'h0, wrReady}, 16'h0001);
    chk({15'h0, companionUnderflow}, 16'h0000);
  endtask
  task automatic testActive();
    logic [15:0] prevCount;
    xfer(2'h2, 16'h0100, 4);
    while (slowTick !== 1'b1) @(negedge clk);
    prevCount = supervCount;
    @(negedge clk);
    chk(supervCount, prevCount - 16'h0001);
  endtask
  task automatic testSave();
    powerSave = 1'b1;
    xfer(2'h3, 16'h005a, 8);
    powerSave = 1'b0;
    chk(supervCount, 16'h0100);
    chk({15'h0, serviceMissed}, 16'h0000);
  endtask
  task automatic testBadKey();
    // Short reload so the crystal scenario reaches a timeout in two ticks
    xfer(2'h2, 16'h0001, 4);
    xfer(2'h3, 16'h0033, 4);
    chk({15'h0, serviceMissed}, 16'h0001);
  endtask
  task automatic testXtal();
    int n = 0;
    useXtal = 1'b1;
    xfer(2'h3, 16'h005a, 4);
    chk(supervCount, 16'h0001);
    while (timeoutPulse !== 1'b1 && n < 20000) begin
      n++;
      @(negedge clk);
    end
    chk({15'h0, timeoutPulse}, 16'h0001);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    testReset();
    testActive();
    testSave();
    testBadKey();
    testXtal();
    endSim();
  end
  // Sized above the longest expected run of the scenarios
  initial begin
    repeat (100000) @(posedge clk);
    badCount++;
    endSim();
  end
endmodule // tb_top
